// ==== hdl/tcwc_pkg.sv ====
/*
 * Constants, field layout and state encoding for the turns counter and
 * wake control block.
 * Assumes a 40 MHz system clock and a 12-bit low-power angle sample.
 */
package tcwc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] ADDR_CONTROL = 8'h1E;
    localparam logic [7:0] ADDR_STATUS = 8'h26;

    // Control fields
    localparam int CTL_RISE_LSB = 0;
    localparam int CTL_HYS_LSB = 3;
    localparam int CTL_STEP45_BIT = 5;
    localparam int CTL_SPECIAL_LSB = 12;
    localparam logic [15:0] CTL_WMASK = 16'h003F;
    localparam logic [15:0] CTL_RESET_VAL = 16'h0020;
    localparam logic [3:0] SPECIAL_TURNS_RESET = 4'h1;

    // Status fields
    localparam int ST_SAT_BIT = 0;
    localparam int ST_BIG_BIT = 3;
    localparam int ST_AWAKE_BIT = 8;
    localparam int ST_SLEEP_BIT = 9;

    // ------------------------------------------------------------------
    // Wake comparator thresholds, millivolts
    // ------------------------------------------------------------------
    localparam int MV_W = 10;
    localparam logic [9:0] RISE_BASE_MV = 10'h12C;
    localparam logic [9:0] RISE_STEP_MV = 10'h032;
    localparam logic [9:0] FALL_FLOOR_MV = 10'h064;
    localparam logic [9:0] HYS0_MV = 10'h032;
    localparam logic [9:0] HYS1_MV = 10'h096;
    localparam logic [9:0] HYS2_MV = 10'h12C;
    localparam logic [9:0] HYS3_MV = 10'h190;

    // ------------------------------------------------------------------
    // Angle and count arithmetic
    // ------------------------------------------------------------------
    localparam int ANGLE_W = 12;
    localparam int POS_W = 24;
    localparam logic [12:0] ANGLE_135 = 13'h0600;
    localparam int SHIFT_45 = 9;
    localparam int SHIFT_180 = 11;
    // Both step modes saturate at the same accumulated-angle bounds
    localparam logic signed [23:0] POS_MAX = 24'sh0FFFFF;
    localparam logic signed [23:0] POS_MIN = 24'shF00000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int WAKE_TIME_US = 160;
    localparam int WAKE_CYCLES = WAKE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam real SLEEP_TIME_MS = 8.192;
    localparam int SLEEP_CYCLES = int'(SLEEP_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int VEL_THRESH_DEF = 256;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'h1,
        ST_AWAKE = 3'h2,
        ST_SLEEP = 3'h4
    } tcwc_state_t;

endpackage

// ==== hdl/tcwc_accum_if.sv ====
/*
 * Carrier between the control logic and the turn accumulator.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface tcwc_accum_if;
    logic sample_valid;
    logic [11:0] angle;
    logic step45;
    logic clear;
    logic [11:0] tally;
    logic [12:0] abs_delta;
    logic sat_evt;
    logic big_evt;
    logic done;

    modport ctrl (output sample_valid, angle, step45, clear,
                  input tally, abs_delta, sat_evt, big_evt, done);
    modport accum (input sample_valid, angle, step45, clear,
                   output tally, abs_delta, sat_evt, big_evt, done);
endinterface

// ==== hdl/tcwc_sync2.sv ====
/*
 * Two-flop level synchroniser.
 * Assumes each bit is an independent level from outside the clock domain.
 */
`timescale 1ns/1ps
module tcwc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// ==== hdl/tcwc_turn_accum.sv ====
/*
 * Turn accumulator: sample-to-sample delta, saturating position, tally.
 * Assumes the first sample after reset only sets the reference angle.
 */
`timescale 1ns/1ps
module tcwc_turn_accum (
    input wire logic clk_in,
    input wire logic reset_in,
    tcwc_accum_if.accum acc
);
    localparam int AW = tcwc_pkg::ANGLE_W;
    localparam int PW = tcwc_pkg::POS_W;

    logic [AW-1:0] prev_reg, prev_next;
    logic primed_reg, primed_next;
    logic signed [PW-1:0] pos_reg, pos_next;
    logic [AW-1:0] tally_reg, tally_next;
    logic [AW:0] absd_reg, absd_next;
    logic sat_reg, sat_next, big_reg, big_next, done_reg, done_next;
    logic signed [AW-1:0] delta;
    logic signed [PW-1:0] sum;
    logic signed [PW-1:0] shifted;

    always_comb begin
        // Modular 12-bit difference: a half-turn jump reads as reverse
        delta = signed'(acc.angle - prev_reg);
        sum = pos_reg + PW'(delta);
        prev_next = prev_reg;
        primed_next = primed_reg;
        pos_next = pos_reg;
        absd_next = absd_reg;
        sat_next = 1'b0;
        big_next = 1'b0;
        done_next = 1'b0;
        if (acc.sample_valid) begin
            prev_next = acc.angle;
            primed_next = 1'b1;
            done_next = 1'b1;
            if (primed_reg) begin
                absd_next = delta[AW-1] ? ((AW + 1)'(0) - (AW + 1)'(delta))
                                        : (AW + 1)'(delta);
                big_next = absd_next > tcwc_pkg::ANGLE_135;
                if (sum > tcwc_pkg::POS_MAX) begin
                    pos_next = tcwc_pkg::POS_MAX;
                    sat_next = 1'b1;
                end else if (sum < tcwc_pkg::POS_MIN) begin
                    pos_next = tcwc_pkg::POS_MIN;
                    sat_next = 1'b1;
                end else begin
                    pos_next = sum;
                end
            end
        end
        if (acc.clear) begin
            pos_next = '0;
        end
        shifted = acc.step45 ? (pos_next >>> tcwc_pkg::SHIFT_45)
                             : (pos_next >>> tcwc_pkg::SHIFT_180);
        tally_next = shifted[AW-1:0];
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            prev_reg <= '0;
            primed_reg <= 1'b0;
            pos_reg <= '0;
            tally_reg <= '0;
            absd_reg <= '0;
            sat_reg <= 1'b0;
            big_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            primed_reg <= primed_next;
            pos_reg <= pos_next;
            tally_reg <= tally_next;
            absd_reg <= absd_next;
            sat_reg <= sat_next;
            big_reg <= big_next;
            done_reg <= done_next;
        end
    end

    assign acc.tally = tally_reg;
    assign acc.abs_delta = absd_reg;
    assign acc.sat_evt = sat_reg;
    assign acc.big_evt = big_reg;
    assign acc.done = done_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_tally_45_bounds: assert property (
        acc.step45 && $stable(acc.step45) |->
        (pos_reg <= tcwc_pkg::POS_MAX && pos_reg >= tcwc_pkg::POS_MIN))
        else $error("tally out of 45-degree range");

    a_tally_180_bounds: assert property (
        !acc.step45 && $stable(acc.step45) |->
        ($signed(tally_reg) <= 12'sh1FF && $signed(tally_reg) >= -12'sh200))
        else $error("tally out of 180-degree range");

    a_big_step_flag: assert property (
        acc.sample_valid && primed_reg && !acc.clear |=>
        (big_reg == (absd_reg > 13'h0600)))
        else $error("large step event mismatch");

    a_clear_zeroes: assert property (
        acc.clear && !acc.sample_valid |=> pos_reg == '0 && tally_reg == '0)
        else $error("counter reset did not clear");
endmodule

// ==== hdl/turns_counter_wake_control.sv ====
/*
 * Turns counter and wake control: register port, low-power state machine,
 * wake comparator threshold selection and sticky warning flags.
 * Assumes angle samples and the low-power request come from logic on
 * clk_in; the wake comparator level arrives asynchronously from the pin.
 */
// Operation
// - Wake input rise forces awake tracking
// - Wake high: stay awake, no angle output
// - Rise threshold 300 to 650 mV, 50 mV steps
// - Hysteresis select; falling threshold floored 100 mV
// - Count step 45 or 180 degrees
// - 45-degree mode saturates +2047 / -2048
// - 180-degree mode saturates +511 / -512
// - Sticky saturation flag until counter reset
// - Update count from sample-to-sample angle difference
// - Half-turn or more reads as reverse rotation
// - Delta above 135 degrees sets warning
// - Count uses only low-power path angle
// - Sleep only when slow and wake low
// - Sleep ends on period expiry or wake
// - Fast rotation keeps device awake and counting
// - Counter reset command clears the count
`timescale 1ns/1ps
module turns_counter_wake_control #(
    parameter int SLEEP_CYCLES = tcwc_pkg::SLEEP_CYCLES,
    parameter int WAKE_CYCLES = tcwc_pkg::WAKE_CYCLES,
    parameter int VEL_THRESH = tcwc_pkg::VEL_THRESH_DEF
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    input wire logic lpm_request_in,
    input wire logic wake_comp_in,
    input wire logic lp_angle_valid_in,
    input wire logic [11:0] lp_angle_in,
    output logic lp_sample_req_out,
    output logic [9:0] wake_thresh_mv_out,
    output logic [11:0] revolution_tally_out,
    output logic awake_out,
    output logic sleep_out,
    output logic angle_out_enable_out
);
    localparam int CYC_W = $clog2(SLEEP_CYCLES + 1);
    localparam int SMP_W = $clog2(WAKE_CYCLES + 1);

    tcwc_accum_if acc_if ();

    // ------------------------------------------------------------------
    // Wake input synchroniser
    // ------------------------------------------------------------------
    logic wake_high;

    tcwc_sync2 #(.W(1)) u_wake_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .async_in(wake_comp_in),
        .sync_out(wake_high)
    );

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] rdata_reg, rdata_next;
    logic clear_reg, clear_next;
    logic sat_flag_reg, sat_flag_next;
    logic big_flag_reg, big_flag_next;
    logic [15:0] status_word;
    logic ctrl_wr;

    always_comb begin
        ctrl_wr = reg_wr_en_in && (reg_addr_in == tcwc_pkg::ADDR_CONTROL);
        ctrl_next = ctrl_reg;
        clear_next = 1'b0;
        if (ctrl_wr) begin
            ctrl_next = reg_wdata_in & tcwc_pkg::CTL_WMASK;
            // Special field is a one-shot command, never stored
            clear_next = reg_wdata_in[tcwc_pkg::CTL_SPECIAL_LSB +: 4]
                         == tcwc_pkg::SPECIAL_TURNS_RESET;
        end
        // Set wins over clear so a saturation in the reset cycle survives
        sat_flag_next = acc_if.sat_evt || (sat_flag_reg && !clear_reg);
        big_flag_next = acc_if.big_evt || (big_flag_reg && !clear_reg);
        status_word = '0;
        status_word[tcwc_pkg::ST_SAT_BIT] = sat_flag_reg;
        status_word[tcwc_pkg::ST_BIG_BIT] = big_flag_reg;
        status_word[tcwc_pkg::ST_AWAKE_BIT] = awake_out;
        status_word[tcwc_pkg::ST_SLEEP_BIT] = sleep_out;
        rdata_next = rdata_reg;
        if (reg_rd_en_in) begin
            if (reg_addr_in == tcwc_pkg::ADDR_CONTROL) begin
                rdata_next = ctrl_reg;
            end else if (reg_addr_in == tcwc_pkg::ADDR_STATUS) begin
                rdata_next = status_word;
            end else begin
                rdata_next = '0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_reg <= tcwc_pkg::CTL_RESET_VAL;
            rdata_reg <= '0;
            clear_reg <= 1'b0;
            sat_flag_reg <= 1'b0;
            big_flag_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            clear_reg <= clear_next;
            sat_flag_reg <= sat_flag_next;
            big_flag_reg <= big_flag_next;
        end
    end

    // ------------------------------------------------------------------
    // Wake comparator threshold
    // ------------------------------------------------------------------
    logic [9:0] thresh_reg, thresh_next;
    logic [9:0] rise_mv, hys_mv, fall_mv;
    logic [2:0] rise_sel;
    logic [1:0] hys_sel;

    always_comb begin
        rise_sel = ctrl_reg[tcwc_pkg::CTL_RISE_LSB +: 3];
        hys_sel = ctrl_reg[tcwc_pkg::CTL_HYS_LSB +: 2];
        rise_mv = tcwc_pkg::RISE_BASE_MV + 10'(rise_sel) * tcwc_pkg::RISE_STEP_MV;
        case (hys_sel)
            2'h0: hys_mv = tcwc_pkg::HYS0_MV;
            2'h1: hys_mv = tcwc_pkg::HYS1_MV;
            2'h2: hys_mv = tcwc_pkg::HYS2_MV;
            default: hys_mv = tcwc_pkg::HYS3_MV;
        endcase
        if (rise_mv >= hys_mv + tcwc_pkg::FALL_FLOOR_MV) begin
            fall_mv = rise_mv - hys_mv;
        end else begin
            fall_mv = tcwc_pkg::FALL_FLOOR_MV;
        end
        // Comparator sees the falling level while high, giving hysteresis
        thresh_next = wake_high ? fall_mv : rise_mv;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            thresh_reg <= tcwc_pkg::RISE_BASE_MV;
        end else begin
            thresh_reg <= thresh_next;
        end
    end

    // ------------------------------------------------------------------
    // Low-power state machine and timers
    // ------------------------------------------------------------------
    tcwc_pkg::tcwc_state_t state_reg, state_next;
    logic [CYC_W-1:0] cyc_reg, cyc_next;
    logic [SMP_W-1:0] smp_reg, smp_next;
    logic req_reg, req_next;
    logic vel_high_reg, vel_high_next;
    logic seen_reg, seen_next;
    logic ang_en_reg, ang_en_next;
    logic cycle_end;

    always_comb begin
        // Cycle timer runs in every state; sleep entry only on its boundary
        cycle_end = cyc_reg == CYC_W'(SLEEP_CYCLES - 1);
        cyc_next = cycle_end ? '0 : cyc_reg + 1'b1;
        vel_high_next = vel_high_reg;
        seen_next = seen_reg;
        if (acc_if.done) begin
            vel_high_next = acc_if.abs_delta >= 13'(VEL_THRESH);
            seen_next = 1'b1;
        end
        state_next = state_reg;
        case (state_reg)
            tcwc_pkg::ST_NORMAL: begin
                if (lpm_request_in) begin
                    state_next = tcwc_pkg::ST_AWAKE;
                end
            end
            tcwc_pkg::ST_AWAKE: begin
                if (!lpm_request_in) begin
                    state_next = tcwc_pkg::ST_NORMAL;
                end else if (cycle_end && !vel_high_reg && !wake_high && seen_reg) begin
                    state_next = tcwc_pkg::ST_SLEEP;
                end
            end
            tcwc_pkg::ST_SLEEP: begin
                if (!lpm_request_in) begin
                    state_next = tcwc_pkg::ST_NORMAL;
                end else if (wake_high || cycle_end) begin
                    state_next = tcwc_pkg::ST_AWAKE;
                end
            end
            default: state_next = tcwc_pkg::ST_NORMAL;
        endcase
        if (state_next == tcwc_pkg::ST_SLEEP) begin
            seen_next = 1'b0;
            smp_next = '0;
        end else if (smp_reg == '0) begin
            smp_next = SMP_W'(WAKE_CYCLES - 1);
        end else begin
            smp_next = smp_reg - 1'b1;
        end
        // Samples at the awake rate while awake, none while asleep
        req_next = (state_next != tcwc_pkg::ST_SLEEP) && (smp_reg == '0);
        ang_en_next = state_next == tcwc_pkg::ST_NORMAL;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= tcwc_pkg::ST_NORMAL;
            cyc_reg <= '0;
            smp_reg <= '0;
            req_reg <= 1'b0;
            vel_high_reg <= 1'b0;
            seen_reg <= 1'b0;
            ang_en_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            smp_reg <= smp_next;
            req_reg <= req_next;
            vel_high_reg <= vel_high_next;
            seen_reg <= seen_next;
            ang_en_reg <= ang_en_next;
        end
    end

    // ------------------------------------------------------------------
    // Turn accumulator
    // ------------------------------------------------------------------
    // Only the low-power path angle feeds the count, uncompensated
    assign acc_if.sample_valid = lp_angle_valid_in;
    assign acc_if.angle = lp_angle_in;
    assign acc_if.step45 = ctrl_reg[tcwc_pkg::CTL_STEP45_BIT];
    assign acc_if.clear = clear_reg;

    tcwc_turn_accum u_accum (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .acc(acc_if.accum)
    );

    assign reg_rdata_out = rdata_reg;
    assign lp_sample_req_out = req_reg;
    assign wake_thresh_mv_out = thresh_reg;
    assign revolution_tally_out = acc_if.tally;
    assign awake_out = state_reg == tcwc_pkg::ST_AWAKE;
    assign sleep_out = state_reg == tcwc_pkg::ST_SLEEP;
    assign angle_out_enable_out = ang_en_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_sleep_entry;
        state_reg == tcwc_pkg::ST_AWAKE ##1 state_reg == tcwc_pkg::ST_SLEEP;
    endsequence

    // Leaving sleep requests at once, so a sleep may cut the gap short
    sequence s_req_gap;
        (!lp_sample_req_out [*8]) or (##[0:7] sleep_out);
    endsequence

    a_sleep_needs_quiet: assert property (
        s_sleep_entry |-> !$past(wake_high) && !$past(vel_high_reg))
        else $error("sleep entered while wake high or fast");

    a_wake_holds_awake: assert property (
        state_reg == tcwc_pkg::ST_AWAKE && wake_high |=> state_reg != tcwc_pkg::ST_SLEEP)
        else $error("left awake state with wake high");

    a_fast_keeps_awake: assert property (
        state_reg == tcwc_pkg::ST_AWAKE && vel_high_reg |=> state_reg != tcwc_pkg::ST_SLEEP)
        else $error("slept while rotating fast");

    a_wake_ends_sleep: assert property (
        sleep_out && lpm_request_in && (wake_high || cycle_end) |=> awake_out)
        else $error("sleep not left on wake or period end");

    a_sleep_in_period: assert property (
        sleep_out && lpm_request_in && cyc_reg == '0 |-> $rose(sleep_out))
        else $error("sleep outlived its period");

    a_no_angle_in_lpm: assert property (
        state_reg != tcwc_pkg::ST_NORMAL |-> !angle_out_enable_out)
        else $error("angle output enabled in low-power state");

    a_sample_spacing: assert property (
        lp_sample_req_out |=> s_req_gap)
        else $error("sample requests too close");

    a_rise_thresh: assert property (
        !wake_high |=> wake_thresh_mv_out ==
        10'h12C + 10'h032 * 10'($past(ctrl_reg[2:0])))
        else $error("rising threshold wrong");

    a_fall_floor: assert property (
        wake_high |=> wake_thresh_mv_out >= 10'h064 &&
        wake_thresh_mv_out < $past(rise_mv))
        else $error("falling threshold wrong");

    a_sat_sticky: assert property (
        sat_flag_reg && !clear_reg |=> sat_flag_reg)
        else $error("saturation flag dropped without reset");

    a_sat_sets: assert property (
        acc_if.sat_evt |=> sat_flag_reg)
        else $error("saturation flag not set");
endmodule

// ==== verification/tcwc_bemf_model.sv ====
/*
 * Partner model: filtered motor back-EMF level seen by the wake comparator.
 * Assumes the bench sets level_mv_in and the design supplies the DAC level.
 */
`timescale 1ns/1ps
module tcwc_bemf_model (
    input wire logic [9:0] level_mv_in,
    input wire logic [9:0] thresh_mv_in,
    output logic comp_out
);
    // Settles a few ns after either side moves, so never on a clock edge
    assign #3 comp_out = (level_mv_in > thresh_mv_in);
endmodule

// ==== verification/tb.sv ====
/*
 * Self-checking bench for the turns counter and wake control block.
 * Assumes short sleep and wake periods via parameters; 40 MHz clock.
 */
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0, reset_in = 1'b1, wr = 1'b0, rd = 1'b0, lpm = 1'b0, vld = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, q;
    logic [11:0] ang = 12'h000, tally;
    logic [9:0] thr, lvl = 10'h000;
    logic wake, awake, slp, aen, sreq;
    int failures = 0, samples_checked = 0, i;
    int hys [4] = '{50, 150, 300, 400};

    tcwc_bemf_model bemf_u (.level_mv_in(lvl), .thresh_mv_in(thr), .comp_out(wake));
    turns_counter_wake_control #(.SLEEP_CYCLES(64), .WAKE_CYCLES(16)) dut_u (
        .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wr_en_in(wr),
        .reg_rd_en_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(q), .lpm_request_in(lpm),
        .wake_comp_in(wake), .lp_angle_valid_in(vld), .lp_angle_in(ang),
        .lp_sample_req_out(sreq), .wake_thresh_mv_out(thr), .revolution_tally_out(tally),
        .awake_out(awake), .sleep_out(slp), .angle_out_enable_out(aen));

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    // --------------------------------
    // Bus and sample tasks
    // --------------------------------
    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(n, e, q);
    endtask
    task automatic samp(input logic [11:0] d);
        @(posedge clk_in);
        ang <= ang + d;
        vld <= 1'b1;
        @(posedge clk_in);
        vld <= 1'b0;
        #1;
    endtask
    // Bounded wait; running out is reported and ends the run
    task automatic wait_slp(input logic v, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(posedge clk_in);
            #1;
            if (slp === v) return;
        end
        chk("sleep_out", {15'h0000, v}, {15'h0000, slp});
        report_and_stop();
    endtask
    task automatic stay(input int n);
        repeat (n) begin
            @(posedge clk_in);
            #1 chk("awake_noangle", 16'h0001, {14'h0000, aen, awake});
        end
    endtask

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        rd_chk("control", tcwc_pkg::ADDR_CONTROL, 16'h0020);
        rd_chk("status", tcwc_pkg::ADDR_STATUS, 16'h0000);
        rd_chk("unmapped", 8'h00, 16'h0000);
        for (i = 0; i < 8; i++) begin
            wr_reg(tcwc_pkg::ADDR_CONTROL, 16'h0020 | i[15:0]);
            repeat (2) @(posedge clk_in);
            #1 chk("rise_mv", 16'(300 + 50 * i), {6'h00, thr});
        end
        lvl <= 10'h3E8;
        for (i = 0; i < 4; i++) begin
            wr_reg(tcwc_pkg::ADDR_CONTROL, 16'h0020 | 16'(i << 3));
            repeat (5) @(posedge clk_in);
            #1 chk("fall_mv", 16'(hys[i] > 200 ? 100 : 300 - hys[i]), {6'h00, thr});
        end
        lvl <= 10'h000;
        wr_reg(tcwc_pkg::ADDR_CONTROL, 16'h0020);
        samp(12'h000);
        chk("tally", 16'h0000, {4'h0, tally});
        samp(12'h700);
        chk("tally", 16'h0003, {4'h0, tally});
        rd_chk("status", tcwc_pkg::ADDR_STATUS, 16'h0008);
        samp(12'h800);
        chk("tally", 16'h0FFF, {4'h0, tally});
        wr_reg(tcwc_pkg::ADDR_CONTROL, 16'h1020);
        rd_chk("status", tcwc_pkg::ADDR_STATUS, 16'h0000);
        chk("tally", 16'h0000, {4'h0, tally});
        for (i = 0; i < 1100; i++) samp(12'h400);
        chk("tally", 16'h07FF, {4'h0, tally});
        samp(12'hC00);
        chk("tally", 16'h07FD, {4'h0, tally});
        rd_chk("status", tcwc_pkg::ADDR_STATUS, 16'h0001);
        wr_reg(tcwc_pkg::ADDR_CONTROL, 16'h1000);
        rd_chk("status", tcwc_pkg::ADDR_STATUS, 16'h0000);
        for (i = 0; i < 1100; i++) samp(12'hC00);
        chk("tally", 16'h0E00, {4'h0, tally});
        wr_reg(tcwc_pkg::ADDR_CONTROL, 16'h1020);
        lpm <= 1'b1;
        samp(12'h000);
        stay(2);
        wait_slp(1'b1, 200);
        rd_chk("status", tcwc_pkg::ADDR_STATUS, 16'h0200);
        wait_slp(1'b0, 100);
        chk("sample_req", 16'h0001, {15'h0000, sreq});
        samp(12'h000);
        wait_slp(1'b1, 200);
        lvl <= 10'h3E8;
        wait_slp(1'b0, 8);
        stay(200);
        lvl <= 10'h000;
        samp(12'h200);
        stay(200);
        lpm <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1 chk("angle_en", 16'h0001, {15'h0000, aen});
        report_and_stop();
    end
endmodule
